//--- design/timer2_core.sv
// Eight-bit timer with two compare channels and its registers.
`timescale 1ns/10ps

`include "timer2_regs.svh"

// What this block does
// - Force strobes act only in non-PWM modes.
// - Force A makes immediate compare event on A.
// - Force B makes immediate compare event on B.
// - Forced compare sets no flag, no clear.
// - Force bits are strobes, read as zero.
// - Clock select picks stop, /1 to /1024.
// - Counter is directly readable and writable.
// - Counter write blocks next tick's compare match.
// - Compare registers compared with counter continuously.
// - Request needs enable, global bit and flag.
// - Compare B match sets flag bit two.
// - Vector entry clears compare B flag.
// - Writing one clears flag; zero keeps it.
// - Flags at 0x37 data, 0x17 I/O.
// - Waveform mode field selects count sequence, top.
// - Non-PWM output modes: off, toggle, clear, set.
// - Overflow flag on overflow or bottom turn.
// - Compare A match sets flag bit one.

module timer2_core
   import timer2_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Processor register port.
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_io_space_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Interrupt handshake with the core.
   input  wire logic       global_irq_enable_i,
   input  wire logic       ack_overflow_i,
   input  wire logic       ack_compare_a_i,
   input  wire logic       ack_compare_b_i,
   output logic            irq_overflow_o,
   output logic            irq_compare_a_o,
   output logic            irq_compare_b_o,
   // Waveform outputs.
   output logic            wave_out_a_o,
   output logic            wave_out_b_o
);

   /****************************************************************/
   /* Register storage.                                            */
   /****************************************************************/
   logic [7:0]                  timer_control_a_q;
   logic [7:0]                  timer_control_b_q;
   logic [7:0]                  timer_count_value_q;
   logic [7:0]                  compare_value_a_q;
   logic [7:0]                  compare_value_b_q;
   logic [2:0]                  timer_irq_enables_q;
   logic [2:0]                  timer_irq_flags_q;
   logic [2:0]                  timer_irq_flags_d;
   logic [`PRESCALE_WIDTH-1:0]  prescale_q;
   logic                        count_down_q;
   logic                        block_match_q;

   logic [7:0]    eff_addr;
   logic          wr_ctrl_a;
   logic          wr_ctrl_b;
   logic          wr_count;
   logic          wr_cmp_a;
   logic          wr_cmp_b;
   logic          wr_enables;
   logic          wr_flags;
   wave_mode_type wave_mode;
   logic [2:0]    clock_select_field;
   logic          pwm_mode;
   logic          top_from_ocr;
   logic [7:0]    top_value;
   logic          tick;
   logic          match_a;
   logic          match_b;
   logic          at_top;
   logic          at_bottom;
   logic          overflow_event;
   logic          force_a;
   logic          force_b;
   logic [7:0]    rdata_d;

   // I/O instructions reach only the low space; extended registers need load/store.
   assign eff_addr = reg_io_space_i ? (reg_addr_i + `IO_SPACE_BASE) : reg_addr_i;

   assign wr_flags   = reg_wr_i && (eff_addr == `IRQ_FLAGS_OFS);
   assign wr_enables = reg_wr_i && !reg_io_space_i && (eff_addr == `IRQ_ENABLES_OFS);
   assign wr_ctrl_a  = reg_wr_i && !reg_io_space_i && (eff_addr == `CONTROL_A_OFS);
   assign wr_ctrl_b  = reg_wr_i && !reg_io_space_i && (eff_addr == `CONTROL_B_OFS);
   assign wr_count   = reg_wr_i && !reg_io_space_i && (eff_addr == `COUNT_VALUE_OFS);
   assign wr_cmp_a   = reg_wr_i && !reg_io_space_i && (eff_addr == `COMPARE_A_OFS);
   assign wr_cmp_b   = reg_wr_i && !reg_io_space_i && (eff_addr == `COMPARE_B_OFS);

   /****************************************************************/
   /* Mode decode.                                                 */
   /****************************************************************/
   assign wave_mode = wave_mode_type'({timer_control_b_q[`BIT_WAVE_HIGH],
                                       timer_control_a_q[1:0]});
   assign clock_select_field = timer_control_b_q[2:0];
   assign pwm_mode = timer_control_a_q[0];
   assign top_from_ocr = (wave_mode == WAVE_CTC) || (wave_mode == WAVE_PC_PWM_OCR)
                         || (wave_mode == WAVE_FAST_OCR);
   assign top_value = top_from_ocr ? compare_value_a_q : `COUNT_MAX;

   // Force strobes live for the write cycle only.
   assign force_a = wr_ctrl_b && reg_wdata_i[`BIT_FORCE_A] && !pwm_mode;
   assign force_b = wr_ctrl_b && reg_wdata_i[`BIT_FORCE_B] && !pwm_mode;

   /****************************************************************/
   /* Prescaler.                                                   */
   /****************************************************************/
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         prescale_q <= '0;
      end
      else
      begin
         prescale_q <= prescale_q + `PRESCALE_WIDTH'(1);
      end
   end

   always_comb
   begin
      case (clock_select_field)
         3'h0:    tick = 1'b0;
         3'h1:    tick = 1'b1;
         3'h2:    tick = (prescale_q & `DIV_8_MASK) == `DIV_8_MASK;
         3'h3:    tick = (prescale_q & `DIV_32_MASK) == `DIV_32_MASK;
         3'h4:    tick = (prescale_q & `DIV_64_MASK) == `DIV_64_MASK;
         3'h5:    tick = (prescale_q & `DIV_128_MASK) == `DIV_128_MASK;
         3'h6:    tick = (prescale_q & `DIV_256_MASK) == `DIV_256_MASK;
         default: tick = prescale_q == `DIV_1024_MASK;
      endcase
   end

   /****************************************************************/
   /* Counter and event detection.                                 */
   /****************************************************************/
   assign at_top    = timer_count_value_q == top_value;
   assign at_bottom = timer_count_value_q == `COUNT_BOTTOM;
   assign match_a = tick && !block_match_q
                    && (timer_count_value_q == compare_value_a_q);
   assign match_b = tick && !block_match_q
                    && (timer_count_value_q == compare_value_b_q);

   assign overflow_event = tick
                           && ((wave_mode == WAVE_PC_PWM) || (wave_mode == WAVE_PC_PWM_OCR)
                               ? at_bottom && count_down_q
                               : (wave_mode == WAVE_FAST_OCR) ? at_top
                               : timer_count_value_q == `COUNT_MAX);

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         timer_count_value_q <= `REG_RESET;
         count_down_q        <= 1'b0;
      end
      else if (wr_count)
      begin
         timer_count_value_q <= reg_wdata_i;
      end
      else if (tick)
      begin
         if (wave_mode == WAVE_PC_PWM || wave_mode == WAVE_PC_PWM_OCR)
         begin
            // Turn down at top and up at bottom; otherwise keep the direction.
            count_down_q        <= count_down_q ? !at_bottom : at_top;
            timer_count_value_q <= (count_down_q ? !at_bottom : at_top)
                                   ? timer_count_value_q - 8'h01
                                   : timer_count_value_q + 8'h01;
         end
         else
         begin
            count_down_q <= 1'b0;
            // Forced compares never reach this clear path.
            if (top_from_ocr && at_top)
            begin
               timer_count_value_q <= `COUNT_BOTTOM;
            end
            else
            begin
               timer_count_value_q <= timer_count_value_q + 8'h01;
            end
         end
      end
   end

   // A counter write masks compares until the next timer tick has passed.
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         block_match_q <= 1'b0;
      end
      else if (wr_count)
      begin
         block_match_q <= 1'b1;
      end
      else if (tick)
      begin
         block_match_q <= 1'b0;
      end
   end

   /****************************************************************/
   /* Control, compare and enable registers.                       */
   /****************************************************************/
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         timer_control_a_q   <= `REG_RESET;
         timer_control_b_q   <= `REG_RESET;
         compare_value_a_q   <= `REG_RESET;
         compare_value_b_q   <= `REG_RESET;
         timer_irq_enables_q <= 3'h0;
      end
      else
      begin
         if (wr_ctrl_a)
         begin
            timer_control_a_q <= reg_wdata_i;
         end
         if (wr_ctrl_b)
         begin
            timer_control_b_q <= {2'h0, 2'h0, reg_wdata_i[3:0]};
         end
         if (wr_cmp_a)
         begin
            compare_value_a_q <= reg_wdata_i;
         end
         if (wr_cmp_b)
         begin
            compare_value_b_q <= reg_wdata_i;
         end
         if (wr_enables)
         begin
            timer_irq_enables_q <= reg_wdata_i[2:0];
         end
      end
   end

   /****************************************************************/
   /* Interrupt flags.                                             */
   /****************************************************************/
   always_comb
   begin
      // Clears first, so a hardware set in the same cycle wins; forces never set a flag.
      timer_irq_flags_d = timer_irq_flags_q & ~({3{wr_flags}} & reg_wdata_i[2:0]);
      timer_irq_flags_d = timer_irq_flags_d & ~{ack_compare_b_i, ack_compare_a_i,
                                                ack_overflow_i};
      timer_irq_flags_d = timer_irq_flags_d | {match_b, match_a,
                                               overflow_event};
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         timer_irq_flags_q <= 3'h0;
         irq_overflow_o    <= 1'b0;
         irq_compare_a_o   <= 1'b0;
         irq_compare_b_o   <= 1'b0;
      end
      else
      begin
         timer_irq_flags_q <= timer_irq_flags_d;
         irq_overflow_o  <= global_irq_enable_i && timer_irq_enables_q[0]
                            && timer_irq_flags_d[`BIT_FLAG_OVF];
         irq_compare_a_o <= global_irq_enable_i && timer_irq_enables_q[1]
                            && timer_irq_flags_d[`BIT_FLAG_A];
         irq_compare_b_o <= global_irq_enable_i && timer_irq_enables_q[2]
                            && timer_irq_flags_d[`BIT_FLAG_B];
      end
   end

   /****************************************************************/
   /* Read data.                                                   */
   /****************************************************************/
   always_comb
   begin
      rdata_d = 8'h00;
      if (reg_rd_i)
      begin
         if (eff_addr == `IRQ_FLAGS_OFS)
         begin
            rdata_d = {5'h00, timer_irq_flags_q};
         end
         else if (!reg_io_space_i)
         begin
            case (eff_addr)
               `IRQ_ENABLES_OFS: rdata_d = {5'h00, timer_irq_enables_q};
               `CONTROL_A_OFS:   rdata_d = timer_control_a_q;
               `CONTROL_B_OFS:   rdata_d = {4'h0, timer_control_b_q[3:0]};
               `COUNT_VALUE_OFS: rdata_d = timer_count_value_q;
               `COMPARE_A_OFS:   rdata_d = compare_value_a_q;
               `COMPARE_B_OFS:   rdata_d = compare_value_b_q;
               default:          rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         reg_rdata_o <= rdata_d;
      end
   end

   /****************************************************************/
   /* Waveform channels.                                           */
   /****************************************************************/
   timer2_wave_channel u_chan_a
   (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .out_mode_i     (out_mode_type'(timer_control_a_q[7:6])),
      .pwm_mode_i     (pwm_mode),
      .top_from_ocr_i (top_from_ocr),
      .count_down_i   (count_down_q),
      .match_i        (match_a),
      .force_i        (force_a),
      .bottom_i       (tick && at_bottom),
      .wave_o         (wave_out_a_o)
   );

   timer2_wave_channel u_chan_b
   (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .out_mode_i     (out_mode_type'(timer_control_a_q[5:4])),
      .pwm_mode_i     (pwm_mode),
      .top_from_ocr_i (1'b0),
      .count_down_i   (count_down_q),
      .match_i        (match_b),
      .force_i        (force_b),
      .bottom_i       (tick && at_bottom),
      .wave_o         (wave_out_b_o)
   );

endmodule

//--- design/timer2_regs.svh
// Register offsets, field positions, reset values and prescaler counts of the timer.
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

`define IRQ_FLAGS_OFS        8'h37
`define IRQ_FLAGS_IO_OFS     8'h17
`define IO_SPACE_BASE        8'h20
`define IRQ_ENABLES_OFS      8'h70
`define CONTROL_A_OFS        8'hB0
`define CONTROL_B_OFS        8'hB1
`define COUNT_VALUE_OFS      8'hB2
`define COMPARE_A_OFS        8'hB3
`define COMPARE_B_OFS        8'hB4

`define REG_RESET            8'h00
`define COUNT_MAX            8'hFF
`define COUNT_BOTTOM         8'h00

`define BIT_FORCE_A          7
`define BIT_FORCE_B          6
`define BIT_WAVE_HIGH        3
`define BIT_FLAG_B           2
`define BIT_FLAG_A           1
`define BIT_FLAG_OVF         0
`define FIELD_OUT_MODE_A_HI  7
`define FIELD_OUT_MODE_A_LO  6
`define FIELD_OUT_MODE_B_HI  5
`define FIELD_OUT_MODE_B_LO  4

`define PRESCALE_WIDTH       10
`define DIV_8_MASK           10'h007
`define DIV_32_MASK          10'h01F
`define DIV_64_MASK          10'h03F
`define DIV_128_MASK         10'h07F
`define DIV_256_MASK         10'h0FF
`define DIV_1024_MASK        10'h3FF

`endif

//--- design/timer2_pkg.sv
// Types shared by the timer design.
package timer2_pkg;

   typedef enum logic [2:0]
   {
      WAVE_NORMAL     = 3'h0,
      WAVE_PC_PWM     = 3'h1,
      WAVE_CTC        = 3'h2,
      WAVE_FAST_PWM   = 3'h3,
      WAVE_RSVD_4     = 3'h4,
      WAVE_PC_PWM_OCR = 3'h5,
      WAVE_RSVD_6     = 3'h6,
      WAVE_FAST_OCR   = 3'h7
   } wave_mode_type;

   typedef enum logic [1:0]
   {
      OUT_DISCONNECT = 2'h0,
      OUT_TOGGLE     = 2'h1,
      OUT_CLEAR      = 2'h2,
      OUT_SET        = 2'h3
   } out_mode_type;

endpackage

//--- design/timer2_wave_channel.sv
// One compare-output channel: drives its waveform pin on matches and forced compares.
`timescale 1ns/10ps

`include "timer2_regs.svh"

module timer2_wave_channel
   import timer2_pkg::*;
(
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // Controls.
   input  wire out_mode_type out_mode_i,
   input  wire logic         pwm_mode_i,
   input  wire logic         top_from_ocr_i,
   input  wire logic         count_down_i,
   input  wire logic         match_i,
   input  wire logic         force_i,
   input  wire logic         bottom_i,
   // Output.
   output logic              wave_o
);

   logic wave_d;

   always_comb
   begin
      wave_d = wave_o;
      if (!pwm_mode_i)
      begin
         if (match_i || force_i)
         begin
            case (out_mode_i)
               OUT_TOGGLE:     wave_d = ~wave_o;
               OUT_CLEAR:      wave_d = 1'b0;
               OUT_SET:        wave_d = 1'b1;
               default:        wave_d = wave_o;
            endcase
         end
      end
      else
      begin
         case (out_mode_i)
            OUT_TOGGLE:
            begin
               if (match_i && top_from_ocr_i)
               begin
                  wave_d = ~wave_o;
               end
            end
            OUT_CLEAR:
            begin
               if (match_i)
               begin
                  wave_d = count_down_i;
               end
               else if (bottom_i && !count_down_i)
               begin
                  wave_d = 1'b1;
               end
            end
            OUT_SET:
            begin
               if (match_i)
               begin
                  wave_d = ~count_down_i;
               end
               else if (bottom_i && !count_down_i)
               begin
                  wave_d = 1'b0;
               end
            end
            default: wave_d = wave_o;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wave_o <= 1'b0;
      end
      else
      begin
         wave_o <= wave_d;
      end
   end

endmodule

//--- verif/cpu_model.sv
// Processor core model issuing register loads and stores to the timer.
`timescale 1ns/10ps

module cpu_model
(
   // Clock and read data.
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   // Register requests.
   output logic      [7:0] addr_o,
   output logic            io_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] wdata_o
);
   // ****************************************
   // Bus access
   // ****************************************
   initial
   begin
      addr_o  = 8'h00;
      io_o    = 1'b0;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      wdata_o = 8'h00;
   end

   // Starts at a falling edge, holds one cycle, then releases for one cycle.
   task automatic access(input logic [7:0] a, input logic s, input logic w,
                         input logic [7:0] d, output logic [7:0] q);
      addr_o  = a;
      io_o    = s; // I/O accesses may aim at any register place, low or extended.
      wr_o    = w;
      rd_o    = !w;
      wdata_o = d;
      @(negedge clk_i);
      q       = rdata_i;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      addr_o  = ~a;
      wdata_o = ~d;
      @(negedge clk_i);
   endtask
endmodule

//--- verif/timer2_core_chk.sv
// Assertion checker for the timer's register and interrupt ports.
`timescale 1ns/10ps

module timer2_core_chk
(
   // Clock and reset.
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_io_space_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Interrupts.
   input wire logic       global_irq_enable_i,
   input wire logic       ack_overflow_i,
   input wire logic       ack_compare_a_i,
   input wire logic       ack_compare_b_i,
   input wire logic       irq_overflow_o,
   input wire logic       irq_compare_a_o,
   input wire logic       irq_compare_b_o
);
   // ****************************************
   // Checks
   // ****************************************
   logic [2:0] clk_sel_q;
   wire        dwr = reg_wr_i && !reg_io_space_i;
   wire        drd = reg_rd_i && !reg_io_space_i;

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         clk_sel_q <= 3'h0;
      end
      else if (dwr && reg_addr_i == 8'hB1)
      begin
         clk_sel_q <= reg_wdata_i[2:0];
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero without a read");
   AST_FORCE_READ_ZERO: assert property (drd && reg_addr_i == 8'hB1 |=>
      reg_rdata_o[7:6] == 2'h0) else $error("force bits read nonzero");
   AST_IO_REFUSE: assert property (reg_rd_i && reg_io_space_i &&
      reg_addr_i != 8'h17 |=> reg_rdata_o == 8'h00) else $error("I/O read answered");
   AST_GLOBAL_GATE: assert property (!global_irq_enable_i |=>
      !(irq_overflow_o || irq_compare_a_o || irq_compare_b_o)) else $error("irq ungated");
   AST_HOLD_B: assert property (irq_compare_b_o && global_irq_enable_i &&
      !ack_compare_b_i && !reg_wr_i |=> irq_compare_b_o) else $error("irq b dropped");
   AST_HOLD_A: assert property (irq_compare_a_o && global_irq_enable_i &&
      !ack_compare_a_i && !reg_wr_i |=> irq_compare_a_o) else $error("irq a dropped");
   AST_HOLD_OVF: assert property (irq_overflow_o && global_irq_enable_i &&
      !ack_overflow_i && !reg_wr_i |=> irq_overflow_o) else $error("irq ovf dropped");
   AST_ENABLE_READBACK: assert property (dwr && reg_addr_i == 8'h70 ##2
      drd && reg_addr_i == 8'h70 |=> ((reg_rdata_o ^ $past(reg_wdata_i, 3)) & 8'h07)
      == 8'h00) else $error("enable readback wrong");
   AST_COUNT_READBACK: assert property (clk_sel_q == 3'h0 && dwr &&
      reg_addr_i == 8'hB2 ##2 drd && reg_addr_i == 8'hB2 |=>
      reg_rdata_o == $past(reg_wdata_i, 3)) else $error("count readback wrong");

   cover property (irq_compare_b_o ##1 ack_compare_b_i);
   cover property (reg_rd_i && reg_io_space_i && reg_addr_i == 8'h17);
   cover property (irq_overflow_o && !global_irq_enable_i);
endmodule

bind timer2_core timer2_core_chk u_timer2_core_chk
(
   .clk_i               (clk_i),
   .sys_rst_i           (sys_rst_i),
   .reg_addr_i          (reg_addr_i),
   .reg_io_space_i      (reg_io_space_i),
   .reg_wr_i            (reg_wr_i),
   .reg_rd_i            (reg_rd_i),
   .reg_wdata_i         (reg_wdata_i),
   .reg_rdata_o         (reg_rdata_o),
   .global_irq_enable_i (global_irq_enable_i),
   .ack_overflow_i      (ack_overflow_i),
   .ack_compare_a_i     (ack_compare_a_i),
   .ack_compare_b_i     (ack_compare_b_i),
   .irq_overflow_o      (irq_overflow_o),
   .irq_compare_a_o     (irq_compare_a_o),
   .irq_compare_b_o     (irq_compare_b_o)
);

//--- verif/testbench.sv
// Self-checking testbench for the timer core.
`timescale 1ns/10ps

`define CHK(n, e, g) check(n, 8'(e), 8'(g))

module testbench;
   // ****************************************
   // Harness
   // ****************************************
   logic       clk_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [7:0] addr, wdata, rdata, q, x;
   logic       io, wr_en, rd, wave_a, wave_b, wexp;
   logic       gie = 1'b0;
   logic [2:0] irq;
   logic [2:0] ack = 3'h0;
   int         error_cnt, tests_run;
   int         seed = 6;
   logic [7:0] ra [5] = '{8'hB2, 8'hB3, 8'hB4, 8'hB1, 8'h70};
   logic [7:0] wm [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hC8, 8'hFF};
   logic [7:0] rm [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h08, 8'h07};
   logic [1:0] fm [4] = '{2'h3, 2'h2, 2'h1, 2'h1};

   always #20 clk_i = ~clk_i;

   timer2_core u_timer2_core
   (
      .clk_i               (clk_i),
      .sys_rst_i           (sys_rst_i),
      .reg_addr_i          (addr),
      .reg_io_space_i      (io),
      .reg_wr_i            (wr_en),
      .reg_rd_i            (rd),
      .reg_wdata_i         (wdata),
      .reg_rdata_o         (rdata),
      .global_irq_enable_i (gie),
      .ack_overflow_i      (ack[0]),
      .ack_compare_a_i     (ack[1]),
      .ack_compare_b_i     (ack[2]),
      .irq_overflow_o      (irq[0]),
      .irq_compare_a_o     (irq[1]),
      .irq_compare_b_o     (irq[2]),
      .wave_out_a_o        (wave_a),
      .wave_out_b_o        (wave_b)
   );

   cpu_model u_cpu_model
   (
      .clk_i   (clk_i),
      .rdata_i (rdata),
      .addr_o  (addr),
      .io_o    (io),
      .wr_o    (wr_en),
      .rd_o    (rd),
      .wdata_o (wdata)
   );

   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      u_cpu_model.access(a, 1'b0, 1'b1, d, r);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic s, input logic [7:0] e,
                        input logic [7:0] m);
      u_cpu_model.access(a, s, 1'b0, 8'h00, q);
      `CHK("reg read", e & m, q & m);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   function automatic int div_of(input int cs);
      int t [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
      return t[cs];
   endfunction

   function automatic logic next_wave(input logic [1:0] m, input logic p);
      return (m == 2'h1) ? ~p : (m == 2'h3) ? 1'b1 : (m == 2'h2) ? 1'b0 : p;
   endfunction

   initial
   begin
      idle(40000);
      error_cnt++;
      finish_test();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      wexp = 1'b0;
      idle(4);
      sys_rst_i = 1'b0;
      foreach (ra[i]) rdchk(ra[i], 1'b0, 8'h00, 8'hFF);
      rdchk(8'h37, 1'b0, 8'h00, 8'hFF);
      rdchk(8'h50, 1'b0, 8'h00, 8'hFF);
      rdchk(8'h91, 1'b1, 8'h00, 8'hFF);
      for (int i = 0; i < 8; i++)
      begin
         x = 8'($random(seed));
         foreach (ra[j])
         begin
            wr(ra[j], x & wm[j]); // Counter is only written while stopped.
            rdchk(ra[j], 1'b0, x & wm[j] & rm[j], 8'hFF);
         end
      end
      for (int cs = 1; cs < 8; cs++)
      begin
         wr(8'hB2, 8'h00);
         wr(8'hB1, 8'(cs));
         idle(4 * div_of(cs) - 2);
         wr(8'hB1, 8'h00);
         rdchk(8'hB2, 1'b0, 8'h04, 8'hFF);
      end
      wr(8'h70, 8'h01);
      gie = 1'b1;
      wr(8'hB2, 8'hFE);
      wr(8'hB1, 8'h01);
      wr(8'hB1, 8'h00);
      idle(2);
      `CHK("irq overflow", 1'b1, irq[0]);
      rdchk(8'h17, 1'b1, 8'h01, 8'h01);
      gie = 1'b0;
      idle(2);
      `CHK("irq gated", 1'b0, irq[0]);
      gie = 1'b1;
      wr(8'h37, 8'h00);
      `CHK("irq kept", 1'b1, irq[0]);
      wr(8'h37, 8'h01);
      `CHK("irq cleared", 1'b0, irq[0]);
      x = 8'h40 + 8'($random(seed) & 8'h3F);
      wr(8'hB3, x);
      wr(8'hB4, x);
      wr(8'hB2, x - 8'h02);
      wr(8'hB1, 8'h01);
      idle(4);
      wr(8'hB1, 8'h00);
      rdchk(8'h37, 1'b0, 8'h06, 8'h06);
      wr(8'h37, 8'h00);
      rdchk(8'h37, 1'b0, 8'h06, 8'h06);
      wr(8'h70, 8'h06);
      `CHK("irq compare", 3'h6, irq);
      ack = 3'h6;
      idle(1);
      ack = 3'h0;
      idle(1);
      `CHK("irq after ack", 3'h0, irq);
      rdchk(8'h37, 1'b0, 8'h00, 8'h06);
      wr(8'hB2, x);
      wr(8'hB1, 8'h01);
      wr(8'hB1, 8'h00);
      rdchk(8'h37, 1'b0, 8'h00, 8'h06);
      wr(8'hB3, 8'h5A);
      wr(8'hB2, 8'h5A);
      foreach (fm[i])
      begin
         wr(8'hB0, {fm[i], fm[i], 4'h2});
         wr(8'hB1, 8'hC0);
         wexp = next_wave(fm[i], wexp);
         `CHK("wave a", wexp, wave_a);
         `CHK("wave b", wexp, wave_b);
      end
      rdchk(8'h37, 1'b0, 8'h00, 8'h07);
      rdchk(8'hB2, 1'b0, 8'h5A, 8'hFF);
      wr(8'hB0, 8'hF3);
      wr(8'hB1, 8'hC0);
      `CHK("wave pwm", 2'h0, {wave_a, wave_b});
      wr(8'hB1, 8'h00); // Control B written to zero again while in PWM; force bits are never stored.
      wr(8'hB0, 8'h01);
      wr(8'hB2, 8'hFD);
      wr(8'hB1, 8'h01);
      idle(4);
      wr(8'hB1, 8'h00);
      rdchk(8'hB2, 1'b0, 8'hFB, 8'hFF);
      wr(8'hB2, 8'h02);
      wr(8'hB1, 8'h01);
      idle(4);
      wr(8'hB1, 8'h00);
      rdchk(8'hB2, 1'b0, 8'h04, 8'hFF);
      rdchk(8'h37, 1'b0, 8'h01, 8'h01);
      finish_test();
   end
endmodule
